// ### pkg/sdc_pkg.sv
// Constants and carrier types for the DRAM command-execution core.
// Assumes all link timing counts are in cycles of the command clock.
package sdc_pkg;

  // Bank and address layout
  localparam int BANKS  = 8;
  localparam int BA_W   = 3;
  localparam int ADDR_W = 14;
  localparam int A_AP   = 10;
  localparam int A_BC   = 12;
  localparam int COL_LO = 3;

  // Burst lengths, as the last beat index
  localparam logic [2:0] LAST_FULL = 3'h7;
  localparam logic [2:0] LAST_CHOP = 3'h3;

  // Timing windows in command clock cycles
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] T_ZQCS   = 10'h040;
  localparam logic [CNT_W-1:0] T_ZQINIT = 10'h200;
  localparam logic [CNT_W-1:0] T_ZQOPER = 10'h100;
  localparam logic [CNT_W-1:0] T_RP     = 10'h004;
  localparam logic [CNT_W-1:0] T_RFC    = 10'h020;

  typedef enum logic [1:0] {
    SDC_IDLE,
    SDC_OPEN,
    SDC_CLOSING
  } sdc_bank_e;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
  } sdc_cmd_s;

  typedef struct packed {
    logic [BANKS-1:0] bank_open;
    logic             cal_busy;
    logic             init_cal_done;
    logic             refresh_busy;
    logic             self_refresh;
  } sdc_status_s;

endpackage

// ### hw/sdc_timer.sv
// Load-and-count-down window timer.
// Assumes load is a single-cycle strobe in the same clock domain.
`timescale 1ns/1ps
module sdc_timer
  import sdc_pkg::*;
#(
  parameter int W = CNT_W
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  // State
  output logic              busy,
  output logic              done
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  assign busy = cnt != '0;
  assign done = cnt == W'(1);

  always_comb begin
    next_cnt = cnt;
    if (load) begin
      next_cnt = value;
    end else if (busy) begin
      next_cnt = cnt - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule

// ### hw/sdc_core.sv
// Command-execution core of a synchronous DRAM: decode, banks, bursts,
// calibration and refresh on the command clock; status on the system clock.
// Assumes commands are synchronous to ck; one data beat per rising ck edge.
//
// Overview of operation
// - Long calibration runs engine, then updates drive code
// - Long calibration gets initial or operational window
// - Short calibration runs a 64-cycle window
// - Activate opens addressed row in selected bank
// - Read burst order from low column bits
// - Address bit ten closes row at burst end
// - Bit twelve picks chop or full burst
// - Started read burst always runs to completion
// - Read decode from strobes with clock enable
// - Write decode from strobes, bank, auto-close
// - Masked bytes leave array location unchanged
// - Precharge closes one bank or all
// - Precharge on idle bank is ignored; retimes closing
// - Refresh row generated inside; address ignored
// - Commands decoded from strobes at rising edge
// - First long calibration after reset uses initial window
// - Deselect and no-op leave operations undisturbed
`timescale 1ns/1ps
module sdc_core
  import sdc_pkg::*;
#(
  parameter int ROW_BITS = 2,
  parameter int COL_BITS = 4,
  parameter int BYTES    = 2,
  parameter int CODE_W   = 6
) (
  // System clock domain
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              otf_enable,
  input  wire logic              burst_interleave,
  input  wire logic              fixed_chop,
  output sdc_status_s            status,
  // Command link
  input  wire logic              ck,
  input  wire sdc_cmd_s          cmd,
  input  wire logic [BA_W-1:0]   ba,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [BYTES-1:0]  dm,
  input  wire logic [8*BYTES-1:0] dq_in,
  output logic [8*BYTES-1:0]     dq_out,
  output logic                   dq_oe,
  // Calibration pin and results
  input  wire logic              zq_above,
  output logic [CODE_W-1:0]      drive_code,
  output logic [ADDR_W-1:0]      refresh_row
);

  localparam int DW = 8 * BYTES;
  localparam int MW = BA_W + ROW_BITS + COL_BITS;
  localparam logic [CODE_W-1:0] CODE_MID = {1'b1, {(CODE_W-1){1'b0}}};

  function automatic logic [2:0] beat_col(input logic [2:0] s,
                                          input logic [2:0] i,
                                          input logic       il);
    logic [1:0] low;
    low = s[1:0] + i[1:0];
    return il ? (s ^ i) : {s[2] ^ i[2], low};
  endfunction

  // Crossings: reset and config into ck, comparator pin into ck
  logic       rst_meta, rst_ck;
  logic [2:0] cfg_meta, cfg;
  logic       zq_meta, zq_cmp;
  always_ff @(posedge ck) begin
    rst_meta <= rst;
    rst_ck   <= rst_meta;
    cfg_meta <= {otf_enable, burst_interleave, fixed_chop};
    cfg      <= cfg_meta;
    zq_meta  <= zq_above;
    zq_cmp   <= zq_meta;
  end

  // Command decode
  logic is_act, is_rd, is_wr, is_pre, is_zq, is_ref, is_sre, cke_q;
  assign is_act = !cmd.cs_n && cmd.cke && !cmd.ras_n && cmd.cas_n
                  && cmd.we_n;
  assign is_rd  = !cmd.cs_n && cmd.cke && cmd.ras_n && !cmd.cas_n
                  && cmd.we_n;
  assign is_wr  = !cmd.cs_n && cmd.cke && cmd.ras_n && !cmd.cas_n
                  && !cmd.we_n;
  assign is_pre = !cmd.cs_n && cmd.cke && !cmd.ras_n && cmd.cas_n
                  && !cmd.we_n;
  assign is_zq  = !cmd.cs_n && cmd.cke && cmd.ras_n && cmd.cas_n
                  && !cmd.we_n;
  assign is_ref = !cmd.cs_n && cke_q && !cmd.ras_n && !cmd.cas_n
                  && cmd.we_n && cmd.cke;
  assign is_sre = !cmd.cs_n && cke_q && !cmd.ras_n && !cmd.cas_n
                  && cmd.we_n && !cmd.cke;

  // Burst engine
  logic [DW-1:0]       mem [2**MW];
  logic                burst_act, burst_rd, burst_ap, burst_chop, burst_il;
  logic [BA_W-1:0]     burst_bank;
  logic [ROW_BITS-1:0] burst_row;
  logic [COL_BITS-1:0] burst_col;
  logic [2:0]          burst_idx;
  logic                next_act, next_rd, next_ap, next_chop, next_il;
  logic [BA_W-1:0]     next_bank;
  logic [ROW_BITS-1:0] next_row;
  logic [COL_BITS-1:0] next_col;
  logic [2:0]          next_idx;
  logic [DW-1:0]       next_dq_out;
  logic                next_dq_oe, burst_end, burst_go;
  logic [BYTES-1:0]    byte_we;
  logic [MW-1:0]       beat_ix;
  logic [ADDR_W-1:0]   bank_row [BANKS];

  assign beat_ix = {burst_bank, burst_row, burst_col[COL_BITS-1:COL_LO],
                    beat_col(burst_col[2:0], burst_idx, burst_il)};
  assign burst_end = burst_act
                     && burst_idx == (burst_chop ? LAST_CHOP : LAST_FULL);
  // A new column command is taken on the last beat, so bursts can chain
  assign burst_go = (is_rd || is_wr) && (!burst_act || burst_end);

  always_comb begin
    next_act    = burst_act;
    next_rd     = burst_rd;
    next_ap     = burst_ap;
    next_chop   = burst_chop;
    next_il     = burst_il;
    next_bank   = burst_bank;
    next_row    = burst_row;
    next_col    = burst_col;
    next_idx    = burst_idx;
    next_dq_out = dq_out;
    next_dq_oe  = 1'b0;
    byte_we     = '0;
    if (burst_act) begin
      if (burst_rd) begin
        next_dq_out = mem[beat_ix];
        next_dq_oe  = 1'b1;
      end else begin
        byte_we = ~dm;
      end
      next_idx = burst_idx + 3'h1;
      if (burst_end) begin
        next_act = 1'b0;
      end
    end
    if (burst_go) begin
      next_act  = 1'b1;
      next_rd   = is_rd;
      next_ap   = addr[A_AP];
      next_chop = cfg[2] ? !addr[A_BC] : cfg[0];
      next_il   = cfg[1];
      next_bank = ba;
      next_row  = bank_row[ba][ROW_BITS-1:0];
      next_col  = addr[COL_BITS-1:0];
      next_idx  = 3'h0;
    end
  end

  always_ff @(posedge ck) begin
    if (rst_ck) begin
      burst_act  <= 1'b0;
      burst_rd   <= 1'b0;
      burst_ap   <= 1'b0;
      burst_chop <= 1'b0;
      burst_il   <= 1'b0;
      burst_bank <= '0;
      burst_row  <= '0;
      burst_col  <= '0;
      burst_idx  <= 3'h0;
      dq_out     <= '0;
      dq_oe      <= 1'b0;
    end else begin
      burst_act  <= next_act;
      burst_rd   <= next_rd;
      burst_ap   <= next_ap;
      burst_chop <= next_chop;
      burst_il   <= next_il;
      burst_bank <= next_bank;
      burst_row  <= next_row;
      burst_col  <= next_col;
      burst_idx  <= next_idx;
      dq_out     <= next_dq_out;
      dq_oe      <= next_dq_oe;
    end
  end

  // Array has no reset; contents are undefined until written
  always_ff @(posedge ck) begin
    for (int i = 0; i < BYTES; i++) begin
      if (byte_we[i]) begin
        mem[beat_ix][8*i +: 8] <= dq_in[8*i +: 8];
      end
    end
  end

  // Bank state
  sdc_bank_e         bank_st [BANKS];
  sdc_bank_e         next_bank_st [BANKS];
  logic [ADDR_W-1:0] next_bank_row [BANKS];
  logic [CNT_W-1:0]  bank_tmr [BANKS];
  logic [CNT_W-1:0]  next_bank_tmr [BANKS];

  always_comb begin
    for (int b = 0; b < BANKS; b++) begin
      next_bank_st[b]  = bank_st[b];
      next_bank_row[b] = bank_row[b];
      next_bank_tmr[b] = bank_tmr[b];
      if (bank_st[b] == SDC_CLOSING) begin
        next_bank_tmr[b] = bank_tmr[b] - CNT_W'(1);
        if (bank_tmr[b] <= CNT_W'(1)) begin
          next_bank_st[b]  = SDC_IDLE;
          next_bank_tmr[b] = '0;
        end
      end
      if (is_act && ba == BA_W'(b)) begin
        next_bank_st[b]  = SDC_OPEN;
        next_bank_row[b] = addr;
      end
      // Idle bank ignores precharge; a closing one restarts its period
      if (is_pre && (addr[A_AP] || ba == BA_W'(b))
          && bank_st[b] != SDC_IDLE) begin
        next_bank_st[b]  = SDC_CLOSING;
        next_bank_tmr[b] = T_RP;
      end
      if (burst_end && burst_ap && burst_bank == BA_W'(b)) begin
        next_bank_st[b]  = SDC_CLOSING;
        next_bank_tmr[b] = T_RP;
      end
    end
  end

  always_ff @(posedge ck) begin
    for (int b = 0; b < BANKS; b++) begin
      if (rst_ck) begin
        bank_st[b]  <= SDC_IDLE;
        bank_row[b] <= '0;
        bank_tmr[b] <= '0;
      end else begin
        bank_st[b]  <= next_bank_st[b];
        bank_row[b] <= next_bank_row[b];
        bank_tmr[b] <= next_bank_tmr[b];
      end
    end
  end

  // Calibration, refresh and self refresh
  logic              cal_busy, cal_done, ref_busy, zq_go;
  logic              zq_init_done, self_ref;
  logic              next_zq_init_done, next_self_ref;
  logic [CODE_W-1:0] cal_code, next_cal_code, next_drive_code;
  logic [ADDR_W-1:0] next_refresh_row;
  logic [CNT_W-1:0]  zq_len;
  sdc_status_s       st_ck, next_st, st_meta;

  assign zq_go  = is_zq && !cal_busy;
  assign zq_len = !addr[A_AP] ? T_ZQCS
                : (zq_init_done ? T_ZQOPER : T_ZQINIT);

  sdc_timer #(.W(CNT_W)) u_zq (
    .clk   (ck),
    .rst   (rst_ck),
    .load  (zq_go),
    .value (zq_len),
    .busy  (cal_busy),
    .done  (cal_done)
  );

  sdc_timer #(.W(CNT_W)) u_rfc (
    .clk   (ck),
    .rst   (rst_ck),
    .load  (is_ref),
    .value (T_RFC),
    .busy  (ref_busy),
    .done  ()
  );

  always_comb begin
    next_zq_init_done = zq_init_done | (zq_go && addr[A_AP]);
    next_cal_code     = cal_code;
    if (cal_busy) begin
      if (zq_cmp && cal_code != '1) begin
        next_cal_code = cal_code + CODE_W'(1);
      end else if (!zq_cmp && cal_code != '0) begin
        next_cal_code = cal_code - CODE_W'(1);
      end
    end
    // Output drive only changes once the whole window has run
    next_drive_code  = cal_done ? cal_code : drive_code;
    next_refresh_row = is_ref ? refresh_row + ADDR_W'(1)
                              : refresh_row;
    next_self_ref    = self_ref;
    if (is_sre) begin
      next_self_ref = 1'b1;
    end else if (self_ref && cmd.cke) begin
      next_self_ref = 1'b0;
    end
    for (int b = 0; b < BANKS; b++) begin
      next_st.bank_open[b] = bank_st[b] == SDC_OPEN;
    end
    next_st.cal_busy      = cal_busy;
    next_st.init_cal_done = zq_init_done;
    next_st.refresh_busy  = ref_busy;
    next_st.self_refresh  = self_ref;
  end

  always_ff @(posedge ck) begin
    if (rst_ck) begin
      cke_q        <= 1'b0;
      zq_init_done <= 1'b0;
      self_ref     <= 1'b0;
      cal_code     <= CODE_MID;
      drive_code   <= CODE_MID;
      refresh_row  <= '0;
      st_ck        <= '0;
    end else begin
      cke_q        <= cmd.cke;
      zq_init_done <= next_zq_init_done;
      self_ref     <= next_self_ref;
      cal_code     <= next_cal_code;
      drive_code   <= next_drive_code;
      refresh_row  <= next_refresh_row;
      st_ck        <= next_st;
    end
  end

  // Status bits are independent levels, so a per-bit two-stage sync works
  always_ff @(posedge clk) begin
    if (rst) begin
      st_meta <= '0;
      status  <= '0;
    end else begin
      st_meta <= st_ck;
      status  <= st_meta;
    end
  end

  // Checks on the command clock
  logic [CNT_W:0]   cal_span;
  logic [CNT_W-1:0] cal_len_q;
  always_ff @(posedge ck) begin
    if (zq_go) begin
      cal_span  <= '0;
      cal_len_q <= zq_len;
    end else if (cal_busy) begin
      cal_span  <= cal_span + (CNT_W+1)'(1);
    end
  end

  default clocking cb @(posedge ck); endclocking
  default disable iff (rst_ck);

  sequence chop_rd_s;
    burst_go && is_rd && (cfg[2] ? !addr[A_BC] : cfg[0]);
  endsequence
  sequence full_rd_s;
    burst_go && is_rd && !(cfg[2] ? !addr[A_BC] : cfg[0]);
  endsequence

  cal_window_a: assert property ($fell(cal_busy) |-> cal_span == cal_len_q)
    else $error("calibration window length wrong");
  zqcs_window_a: assert property (zq_go && !addr[A_AP] |=> u_zq.cnt == 64)
    else $error("short calibration window not 64 cycles");
  drive_xfer_a: assert property (cal_done |=> drive_code == $past(cal_code))
    else $error("drive code not updated at end of calibration");
  act_open_a: assert property (is_act |=> bank_row[$past(ba)] == $past(addr))
    else $error("activate did not capture row");
  // Read data leaves one edge after the burst engine starts
  chop_burst_a: assert property (chop_rd_s |=> ##1 dq_oe [*4])
    else $error("chopped read burst not four beats");
  full_burst_a: assert property (full_rd_s |=> ##1 dq_oe [*8])
    else $error("full read burst interrupted");
  pre_all_a: assert property (is_pre && addr[A_AP] |=>
      !(bank_st[0] == SDC_OPEN || bank_st[7] == SDC_OPEN))
    else $error("precharge all left a bank open");
  pre_retime_a: assert property (is_pre && !addr[A_AP]
      && bank_st[ba] == SDC_CLOSING |=> bank_tmr[$past(ba)] == T_RP)
    else $error("precharge period not restarted");
  ref_row_a: assert property (is_ref |=>
      refresh_row == $past(refresh_row) + ADDR_W'(1))
    else $error("refresh row not advanced");
  mask_store_a: assert property (burst_act && !burst_rd |->
      byte_we == ~dm)
    else $error("byte mask not honoured");
  nop_keep_a: assert property (cmd.cs_n && !cal_done |=>
      $stable(drive_code) && $stable(refresh_row))
    else $error("deselect disturbed state");

endmodule

// ### verification/sdc_ctl_model.sv
// Controller-side model that issues link commands and moves burst data.
// Assumes ck runs free; every output changes at the falling edge of ck.
`timescale 1ns/1ps
module sdc_ctl_model
  import sdc_pkg::*;
(
  // Link clock
  input  wire logic              ck,
  // Command and write data toward the core
  output sdc_cmd_s               cmd,
  output logic [BA_W-1:0]        ba,
  output logic [ADDR_W-1:0]      addr,
  output logic [1:0]             dm,
  output logic [15:0]            dq_in,
  // Read data from the core
  input  wire logic [15:0]       dq_out,
  input  wire logic              dq_oe
);
  // Clock enable stays high throughout; self refresh is never entered
  initial begin
    cmd   = 5'h0f;
    ba    = 3'h0;
    addr  = 14'h0000;
    dm    = 2'h0;
    dq_in = 16'h0000;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge ck);
  endtask

  // Released lines show the inverse so a stale value is never trusted
  task automatic issue(input logic [4:0] c, input logic [2:0] b,
                       input logic [13:0] a);
    @(negedge ck);
    cmd  = c;
    ba   = b;
    addr = a;
    @(negedge ck);
    cmd  = 5'h0f;
    ba   = ~b;
    addr = ~a;
  endtask

  task automatic act(input logic [2:0] b, input logic [13:0] a);
    issue(5'h07, b, a);
    idle(2);
  endtask

  // Full precharge wait before anything else reaches the bank
  task automatic pre(input logic [2:0] b, input logic [13:0] a);
    issue(5'h05, b, a);
    idle(T_RP + 3);
  endtask

  // One refresh at a time, far below any posting or density limit
  task automatic refresh(input logic [13:0] a);
    issue(5'h03, 3'h5, a);
  endtask

  task automatic zq(input logic long_cal);
    issue(5'h0d, 3'h0, {3'h0, long_cal, 10'h000});
  endtask

  task automatic write(input logic [2:0] b, input logic [13:0] a,
                       input int n, input logic [15:0] d [8],
                       input logic [1:0] m);
    issue(5'h09, b, a);
    for (int i = 0; i < n; i++) begin
      dm    = m;
      dq_in = d[i];
      @(negedge ck);
    end
    dm    = ~m;
    dq_in = ~dq_in;
  endtask

  // Nothing is issued while the burst runs
  task automatic read(input logic [2:0] b, input logic [13:0] a,
                      output logic [15:0] q [8], output int n);
    n = 0;
    issue(5'h0b, b, a);
    for (int i = 0; i < 9; i++) begin
      @(negedge ck);
      if (dq_oe === 1'b1 && n < 8) begin
        q[n] = dq_out;
        n++;
      end
    end
  endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the DRAM command-execution core.
// Assumes the controller model drives the link; the bench owns clocks.
`timescale 1ns/1ps
module tb_top;
  import sdc_pkg::*;
  logic        clk, rst, ck, otf_enable, burst_interleave;
  logic        fixed_chop, zq_above, dq_oe;
  sdc_status_s status;
  sdc_cmd_s    cmd;
  logic [2:0]  ba;
  logic [13:0] addr, refresh_row;
  logic [1:0]  dm;
  logic [15:0] dq_in, dq_out;
  logic [5:0]  drive_code;
  logic [15:0] mem [8];
  logic [15:0] wd [8];
  logic [15:0] q [8];
  int          n, num_errors, checks_done;

  sdc_core DUT (.clk(clk), .rst(rst), .otf_enable(otf_enable),
    .burst_interleave(burst_interleave), .fixed_chop(fixed_chop),
    .status(status), .ck(ck), .cmd(cmd), .ba(ba), .addr(addr), .dm(dm),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .zq_above(zq_above),
    .drive_code(drive_code), .refresh_row(refresh_row));

  sdc_ctl_model u_ctl (.ck(ck), .cmd(cmd), .ba(ba), .addr(addr), .dm(dm),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

  // Link clock phase is offset so the two domains never line up
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    ck = 1'b0;
    #7;
    forever #32 ck = ~ck;
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [2:0] col_at(logic [2:0] s, logic [2:0] i,
                                        logic il);
    return il ? (s ^ i) : {s[2] ^ i[2], s[1:0] + i[1:0]};
  endfunction

  task automatic rd_chk(input string what, input logic [13:0] a,
                        input int beats, input logic il);
    u_ctl.read(3'h2, a, q, n);
    chk({what, " beats"}, n, beats);
    for (int i = 0; i < beats; i++)
      chk(what, q[i], mem[col_at(a[2:0], i[2:0], il)]);
  endtask

  task automatic set_level(input int sel, input logic v);
    @(negedge clk);
    case (sel)
      0: otf_enable = v;
      1: burst_interleave = v;
      2: fixed_chop = v;
      default: zq_above = v;
    endcase
    u_ctl.idle(3);
  endtask

  initial begin
    #500000;
    num_errors++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    otf_enable = 1'b1;
    burst_interleave = 1'b0;
    fixed_chop = 1'b0;
    zq_above = 1'b0;
    num_errors = 0;
    checks_done = 0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    u_ctl.idle(3);
    chk("drive_code", drive_code, 32'h20);
    chk("dq_oe", dq_oe, 32'h0);
    chk("status", status, 32'h0);
    $display("test reset done");

    u_ctl.act(3'h2, 14'h0001);
    u_ctl.act(3'h1, 14'h0002);
    u_ctl.act(3'h3, 14'h0003);
    u_ctl.idle(2);
    chk("bank_open", status.bank_open, 32'h0e);
    u_ctl.pre(3'h1, 14'h0000);
    chk("bank_open", status.bank_open, 32'h0c);
    u_ctl.pre(3'h1, 14'h0000);
    chk("bank_open", status.bank_open, 32'h0c);
    $display("test banks done");

    // Full burst stores all bytes, then a masked chop over the top half
    for (int i = 0; i < 8; i++) begin
      wd[i] = {8'ha0 + 8'(i), 8'h50 + 8'(i)};
      mem[i] = wd[i];
    end
    u_ctl.write(3'h2, 14'h1000, 8, wd, 2'b00);
    for (int i = 0; i < 8; i++)
      wd[i] = {8'hc0 + 8'(i), 8'h30 + 8'(i)};
    for (int i = 0; i < 4; i++)
      mem[4 + i] = {mem[4 + i][15:8], wd[i][7:0]};
    u_ctl.write(3'h2, 14'h0004, 4, wd, 2'b10);
    u_ctl.idle(2);
    $display("test write done");

    rd_chk("chop seq", 14'h0005, 4, 1'b0);
    set_level(1, 1'b1);
    rd_chk("full il", 14'h1003, 8, 1'b1);
    set_level(0, 1'b0);
    set_level(2, 1'b1);
    rd_chk("fixed chop", 14'h1006, 4, 1'b1);
    set_level(0, 1'b1);
    rd_chk("autoclose", 14'h0402, 4, 1'b1);
    u_ctl.idle(T_RP + 3);
    chk("bank_open", status.bank_open, 32'h08);
    u_ctl.pre(3'h1, 14'h0400);
    chk("bank_open", status.bank_open, 32'h00);
    $display("test read done");

    for (int r = 1; r <= 2; r++) begin
      u_ctl.refresh(14'h2a5c ^ 14'(r * 14'h1111));
      // Status reaches clk two flops after the ck-domain copy
      u_ctl.idle(2);
      chk("refresh_busy", status.refresh_busy, 32'h1);
      u_ctl.idle(T_RFC);
      chk("refresh_row", refresh_row, 32'(r));
    end
    $display("test refresh done");

    u_ctl.zq(1'b1);
    u_ctl.idle(500);
    chk("drive_code", drive_code, 32'h20);
    u_ctl.idle(20);
    chk("drive_code", drive_code, 32'h00);
    chk("init_cal_done", status.init_cal_done, 32'h1);
    set_level(3, 1'b1);
    u_ctl.zq(1'b0);
    u_ctl.idle(58);
    chk("drive_code", drive_code, 32'h00);
    u_ctl.idle(12);
    chk("drive_code", drive_code, 32'h3f);
    set_level(3, 1'b0);
    u_ctl.zq(1'b1);
    u_ctl.idle(248);
    chk("drive_code", drive_code, 32'h3f);
    u_ctl.idle(15);
    chk("drive_code", drive_code, 32'h00);
    $display("test calibration done");
    print_verdict();
  end
endmodule
